/* inc/sdbt_pkg.sv */
// Shared constants, types and decode helpers for the split dual byte timer.
// Assumes a byte-wide register port and one 40 MHz peripheral clock.
package sdbt_pkg;

   // Register offsets
   localparam logic [3:0] ADDR_CLK   = 4'h0;
   localparam logic [3:0] ADDR_OE    = 4'h1;
   localparam logic [3:0] ADDR_OV    = 4'h2;
   localparam logic [3:0] ADDR_MODE  = 4'h4;
   localparam logic [3:0] ADDR_UIRQ  = 4'h6;
   localparam logic [3:0] ADDR_CIRQ  = 4'h7;
   localparam logic [3:0] ADDR_CMD   = 4'h8;
   localparam logic [3:0] ADDR_FLAGS = 4'hc;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_NIB  = 4'h0;
   localparam logic [1:0] RST_PAIR = 2'h0;

   // Field positions
   localparam int CLK_MSB   = 3;
   localparam int CMD_MSB   = 3;
   localparam int CMD_LSB   = 2;
   localparam int TGT_MSB   = 1;
   localparam int TGT_LSB   = 0;
   localparam int TGT_LOW   = 0;
   localparam int TGT_HIGH  = 1;
   localparam int MODE_MSB  = 1;
   localparam int UIRQ_MSB  = 3;
   localparam int FLAG_LUNF = 0;
   localparam int FLAG_HUNF = 1;
   localparam int FLAG_CMP  = 4;
   localparam int EV_MSB    = 2;
   localparam int PRE_W     = 10;

   // Clock source codes
   localparam logic [3:0] SEL_OFF  = 4'h0;
   localparam logic [3:0] SEL_DIV1 = 4'h1;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_UPPER0 = 2'b01,
      MODE_DUAL   = 2'b10,
      MODE_RSVD   = 2'b11
   } sdbt_mode_t;

   typedef enum logic [1:0] {
      CMD_NONE    = 2'b00,
      CMD_RSVD    = 2'b01,
      CMD_RESTART = 2'b10,
      CMD_HRESET  = 2'b11
   } sdbt_cmd_t;

   // Period and compare values of both halves
   typedef struct packed {
      logic [7:0]      low_per;
      logic [7:0]      high_per;
      logic [3:0][7:0] low_cmp;
      logic [3:0][7:0] high_cmp;
   } sdbt_cfg_t;

   // Interrupt requests, level zero means none
   typedef struct packed {
      logic [3:0][1:0] low_cmp;
      logic [1:0]      high_unf;
      logic [1:0]      low_unf;
   } sdbt_irq_t;

   // Prescaler tick mask for codes 1..7: /1 /2 /4 /8 /64 /256 /1024
   function automatic logic [PRE_W-1:0] sdbt_div_mask(input logic [2:0] code);
      case (code)
         3'h2:    sdbt_div_mask = 10'h001;
         3'h3:    sdbt_div_mask = 10'h003;
         3'h4:    sdbt_div_mask = 10'h007;
         3'h5:    sdbt_div_mask = 10'h03f;
         3'h6:    sdbt_div_mask = 10'h0ff;
         3'h7:    sdbt_div_mask = 10'h3ff;
         default: sdbt_div_mask = 10'h000;
      endcase
   endfunction : sdbt_div_mask

   // Request level of a source: its level field while its flag stands
   function automatic logic [1:0] sdbt_gate(input logic [1:0] lvl, input logic flag);
      sdbt_gate = flag ? lvl : 2'h0;
   endfunction : sdbt_gate

endpackage : sdbt_pkg

/* hw/sdbt_prescaler.sv */
// Clock source selection: prescaled peripheral clock or event channel.
// Assumes event inputs are synchronous one-cycle strobes on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module sdbt_prescaler (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [3:0] clk_sel,
   input  wire logic [7:0] event_in,
   output logic            tick
);
   import sdbt_pkg::*;

   logic [PRE_W-1:0] div_reg;
   logic [PRE_W-1:0] mask;
   logic             div_tick;
   logic             tick_next;

   // Free running divider shared by the divided codes 1 to 7
   assign mask      = sdbt_div_mask(clk_sel[EV_MSB:0]);
   assign div_tick  = (div_reg & mask) == mask;
   assign tick_next = clk_sel[CLK_MSB] ? event_in[clk_sel[EV_MSB:0]]
                    : (clk_sel != SEL_OFF) && div_tick;

   // Divider and registered tick
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_reg <= '0;
         tick    <= 1'b0;
      end else begin
         div_reg <= div_reg + 10'h001;
         tick    <= tick_next;
      end
   end
endmodule : sdbt_prescaler
`default_nettype wire

/* hw/sdbt_half_counter.sv */
// One eight-bit down counting half with four compare channels.
// Assumes the parent chains halves for 16-bit work through dec_en and wrap_ok.
`timescale 1ns/1ps
`default_nettype none
module sdbt_half_counter (
   input  wire logic            ref_clk,
   input  wire logic            rst,
   input  wire logic            tick,
   input  wire logic            dec_en,
   input  wire logic            wrap_ok,
   input  wire logic            zero_force,
   input  wire logic            restart,
   input  wire logic            timer_off,
   input  wire logic [7:0]      per,
   input  wire logic [3:0][7:0] cmp,
   input  wire logic [3:0]      wave_val,
   output logic      [7:0]      cnt,
   output logic      [3:0]      wave,
   output logic                 unf,
   output logic      [3:0]      cmp_hit
);
   import sdbt_pkg::*;

   logic wrap;

   // Bottom reached while the other half allows a reload
   assign wrap = (cnt == RST_BYTE) && wrap_ok;
   assign unf  = tick && wrap && !zero_force;

   // Count down, reload after bottom on the next clock
   always_ff @(posedge ref_clk) begin
      if (rst || restart) begin
         cnt <= RST_BYTE;
      end else if (tick) begin
         if (zero_force) begin
            cnt <= RST_BYTE;
         end else if (wrap) begin
            cnt <= per;
         end else if (dec_en) begin
            cnt <= cnt - 8'h01;
         end
      end
   end

   // Compare channels: set on match, cleared at bottom, match wins
   genvar i;
   for (i = 0; i < 4; i++) begin : g_ch
      assign cmp_hit[i] = tick && (cnt == cmp[i]);
      always_ff @(posedge ref_clk) begin
         if (rst || restart) begin
            wave[i] <= 1'b0;
         end else if (timer_off) begin
            wave[i] <= wave_val[i];
         end else if (cmp_hit[i]) begin
            wave[i] <= 1'b1;
         end else if (tick && wrap) begin
            wave[i] <= 1'b0;
         end
      end
   end
endmodule : sdbt_half_counter
`default_nettype wire

/* hw/sdbt_regs.sv */
// Register set and control of the split dual byte timer pair.
// Assumes a byte register port with read data one cycle after the strobe,
// and period and compare values supplied by neighbouring logic.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Clock code zero stops both halves.
// - Codes 1 to 7 pick clock divided by 1,2,4,8,64,256,1024.
// - Codes with top bit set pick event channel of the low three bits.
// - One clock selection drives both halves alike.
// - Eight enable bits route each compare output over the port value.
// - While stopped, value bits drive the waveform levels directly.
// - Mode 00 is 16-bit, 10 is two byte counters, 11 reserved.
// - Mode 01 zeroes the upper byte after every counter clock.
// - Bits 3:2 set high underflow interrupt level.
// - Bits 1:0 set low underflow interrupt level.
// - Four level pairs enable low compare interrupts D down to A.
// - Command field always reads as zero.
// - Code 10 restarts, 11 hard resets only while stopped.
// - Target field picks low, high or both halves for a command.
// - In mode 10 each half counts down to zero then reloads its period.
// - Restart zeroes the counter and all compare outputs.
// - Underflow flag sets at bottom, clears when its vector runs.
// - Flag register holds compare D..A high, underflows low; write one clears.
module sdbt_regs (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [3:0]       addr,
   input  wire logic [7:0]       wr_data,
   input  wire logic             wr_en,
   input  wire logic             rd_en,
   output logic      [7:0]       rd_data,
   input  wire logic [7:0]       event_in,
   input  wire sdbt_pkg::sdbt_cfg_t cfg,
   input  wire logic [7:0]       irq_vec_done,
   output logic      [7:0]       wg_out,
   output logic      [7:0]       out_override,
   output logic      [7:0]       low_count,
   output logic      [7:0]       high_count,
   output sdbt_pkg::sdbt_irq_t   irq_req
);
   import sdbt_pkg::*;

   // Software registers
   logic [3:0]  clk_sel_reg;
   logic [7:0]  out_en_reg;
   logic [7:0]  out_val_reg;
   sdbt_mode_t  mode_reg;
   logic [3:0]  unf_lvl_reg;
   logic [7:0]  cmp_lvl_reg;
   logic [1:0]  cmd_tgt_reg;
   logic [7:0]  flags_reg;
   logic [7:0]  flags_next;
   sdbt_irq_t   irq_next;
   logic [7:0]  rd_mux;

   // Write decode
   logic        wr_clk;
   logic        wr_oe;
   logic        wr_ov;
   logic        wr_mode;
   logic        wr_uirq;
   logic        wr_cirq;
   logic        wr_cmd;
   logic        wr_flags;

   // Control decode
   sdbt_cmd_t   cmd_code;
   logic [1:0]  cmd_tgt;
   logic        timer_off;
   logic        dual;
   logic        upper0;
   logic        restart_lo;
   logic        restart_hi;
   logic        hreset_lo;
   logic        hreset_hi;
   logic        clear_lo;
   logic        clear_hi;

   // Counter side
   logic        presc_tick;
   logic        lo_zero;
   logic        hi_zero;
   logic        lo_unf;
   logic        hi_unf;
   logic [3:0]  lo_hit;
   logic [3:0]  lo_wave;
   logic [3:0]  hi_wave;
   logic [7:0]  flag_set;
   logic [7:0]  flag_clr;
   logic [7:0]  hreset_mask;
   logic        ev_pick;

   // Address decode of the write strobe
   assign wr_clk   = wr_en && (addr == ADDR_CLK);
   assign wr_oe    = wr_en && (addr == ADDR_OE);
   assign wr_ov    = wr_en && (addr == ADDR_OV);
   assign wr_mode  = wr_en && (addr == ADDR_MODE);
   assign wr_uirq  = wr_en && (addr == ADDR_UIRQ);
   assign wr_cirq  = wr_en && (addr == ADDR_CIRQ);
   assign wr_cmd   = wr_en && (addr == ADDR_CMD);
   assign wr_flags = wr_en && (addr == ADDR_FLAGS);

   // Mode selection; reserved code 11 behaves as plain 16-bit
   assign dual      = (mode_reg == MODE_DUAL);
   assign upper0    = (mode_reg == MODE_UPPER0);
   assign timer_off = (clk_sel_reg == SEL_OFF);

   // Commands act only in the write cycle; the code itself is not kept
   assign cmd_code   = sdbt_cmd_t'(wr_data[CMD_MSB:CMD_LSB]);
   assign cmd_tgt    = wr_data[TGT_MSB:TGT_LSB];
   assign restart_lo = wr_cmd && (cmd_code == CMD_RESTART)
                       && cmd_tgt[TGT_LOW];
   assign restart_hi = wr_cmd && (cmd_code == CMD_RESTART)
                       && cmd_tgt[TGT_HIGH];
   assign hreset_lo  = wr_cmd && (cmd_code == CMD_HRESET)
                       && cmd_tgt[TGT_LOW] && timer_off;
   assign hreset_hi  = wr_cmd && (cmd_code == CMD_HRESET)
                       && cmd_tgt[TGT_HIGH] && timer_off;
   assign clear_lo   = restart_lo || hreset_lo;
   assign clear_hi   = restart_hi || hreset_hi;

   // Shared clock source for both halves
   sdbt_prescaler u_presc (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clk_sel  (clk_sel_reg),
      .event_in (event_in),
      .tick     (presc_tick)
   );

   // Chaining: in 16-bit work the high half borrows from the low half
   assign lo_zero = (low_count == RST_BYTE);
   assign hi_zero = (high_count == RST_BYTE);

   sdbt_half_counter u_low (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .tick       (presc_tick),
      .dec_en     (1'b1),
      .wrap_ok    (dual || upper0 || hi_zero),
      .zero_force (1'b0),
      .restart    (clear_lo),
      .timer_off  (timer_off),
      .per        (cfg.low_per),
      .cmp        (cfg.low_cmp),
      .wave_val   (out_val_reg[3:0]),
      .cnt        (low_count),
      .wave       (lo_wave),
      .unf        (lo_unf),
      .cmp_hit    (lo_hit)
   );

   sdbt_half_counter u_high (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .tick       (presc_tick),
      .dec_en     (dual || lo_zero),
      .wrap_ok    (dual || lo_zero),
      .zero_force (upper0),
      .restart    (clear_hi),
      .timer_off  (timer_off),
      .per        (cfg.high_per),
      .cmp        (cfg.high_cmp),
      .wave_val   (out_val_reg[7:4]),
      .cnt        (high_count),
      .wave       (hi_wave),
      .unf        (hi_unf),
      .cmp_hit    ()
   );

   // Flag update: hardware set wins over any clear in the same cycle
   assign flag_set    = {lo_hit, 2'b00, hi_unf, lo_unf};
   assign hreset_mask = {{4{hreset_lo}}, 2'b00, hreset_hi, hreset_lo};
   assign flag_clr    = (wr_flags ? wr_data : RST_BYTE)
                        | irq_vec_done | hreset_mask;
   assign flags_next  = (flags_reg & ~flag_clr) | flag_set;

   // Interrupt requests follow the stored flags
   assign irq_next.low_unf  = sdbt_gate(unf_lvl_reg[1:0], flags_reg[FLAG_LUNF]);
   assign irq_next.high_unf = sdbt_gate(unf_lvl_reg[3:2], flags_reg[FLAG_HUNF]);
   genvar c;
   for (c = 0; c < 4; c++) begin : g_cirq
      assign irq_next.low_cmp[c] = sdbt_gate(cmp_lvl_reg[2*c+1 -: 2],
                                             flags_reg[FLAG_CMP+c]);
   end

   // Read selection; unmapped offsets read zero
   assign rd_mux = (addr == ADDR_CLK)   ? {RST_NIB, clk_sel_reg}
                 : (addr == ADDR_OE)    ? out_en_reg
                 : (addr == ADDR_OV)    ? out_val_reg
                 : (addr == ADDR_MODE)  ? {6'h00, mode_reg}
                 : (addr == ADDR_UIRQ)  ? {RST_NIB, unf_lvl_reg}
                 : (addr == ADDR_CIRQ)  ? cmp_lvl_reg
                 : (addr == ADDR_CMD)   ? {6'h00, cmd_tgt_reg}
                 : (addr == ADDR_FLAGS) ? flags_reg
                 : RST_BYTE;

   // Control registers; reserved bits are not stored and read zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clk_sel_reg <= SEL_OFF;
         out_en_reg  <= RST_BYTE;
         out_val_reg <= RST_BYTE;
         mode_reg    <= MODE_NORMAL;
         unf_lvl_reg <= RST_NIB;
         cmp_lvl_reg <= RST_BYTE;
         cmd_tgt_reg <= RST_PAIR;
      end else begin
         if (wr_clk)  clk_sel_reg <= wr_data[CLK_MSB:0];
         if (wr_oe)   out_en_reg  <= wr_data;
         if (wr_ov)   out_val_reg <= wr_data;
         if (wr_mode) mode_reg    <= sdbt_mode_t'(wr_data[MODE_MSB:0]);
         if (wr_uirq) unf_lvl_reg <= wr_data[UIRQ_MSB:0];
         if (wr_cirq) cmp_lvl_reg <= wr_data;
         if (wr_cmd)  cmd_tgt_reg <= cmd_tgt;
      end
   end

   // Flags, read data and registered outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flags_reg    <= RST_BYTE;
         rd_data      <= RST_BYTE;
         wg_out       <= RST_BYTE;
         out_override <= RST_BYTE;
         irq_req      <= '0;
      end else begin
         flags_reg    <= flags_next;
         rd_data      <= rd_en ? rd_mux : RST_BYTE;
         wg_out       <= {hi_wave, lo_wave};
         out_override <= out_en_reg;
         irq_req      <= irq_next;
      end
   end

   // Checks
   assign ev_pick = event_in[clk_sel_reg[EV_MSB:0]];

   chk_off_no_tick: assert property (
      @(posedge ref_clk) disable iff (rst)
      (clk_sel_reg == SEL_OFF) |=> !presc_tick)
      else $error("timer ticked while clock source is off");

   chk_div1_tick: assert property (
      @(posedge ref_clk) disable iff (rst)
      (clk_sel_reg == SEL_DIV1) |=> presc_tick)
      else $error("undivided clock source missed a tick");

   chk_event_clock: assert property (
      @(posedge ref_clk) disable iff (rst)
      clk_sel_reg[CLK_MSB] |=> (presc_tick == $past(ev_pick)))
      else $error("event clock does not follow the chosen channel");

   chk_cmd_reads_zero: assert property (
      @(posedge ref_clk) disable iff (rst)
      (rd_en && addr == ADDR_CMD) |=> (rd_data[CMD_MSB:CMD_LSB] == 2'b00))
      else $error("command field read back nonzero");

   chk_restart_clears: assert property (
      @(posedge ref_clk) disable iff (rst)
      restart_lo |=> (low_count == RST_BYTE) ##1 (wg_out[3:0] == 4'h0))
      else $error("restart did not clear the low half");

   chk_upper_zeroed: assert property (
      @(posedge ref_clk) disable iff (rst)
      (upper0 && presc_tick && !clear_hi) |=> (high_count == RST_BYTE))
      else $error("upper byte not zeroed in upper zero mode");

   chk_unf_flag_sets: assert property (
      @(posedge ref_clk) disable iff (rst)
      lo_unf |=> flags_reg[FLAG_LUNF])
      else $error("low underflow did not set its flag");

   chk_flag_w1c: assert property (
      @(posedge ref_clk) disable iff (rst)
      (wr_flags && wr_data[FLAG_HUNF] && !hi_unf) |=> !flags_reg[FLAG_HUNF])
      else $error("write one did not clear the high underflow flag");

   chk_irq_level: assert property (
      @(posedge ref_clk) disable iff (rst)
      flags_reg[FLAG_LUNF]
      |=> (irq_req.low_unf == $past(unf_lvl_reg[1:0])))
      else $error("low underflow request level wrong");

   chk_hreset_guard: assert property (
      @(posedge ref_clk) disable iff (rst)
      (wr_cmd && cmd_code == CMD_HRESET && cmd_tgt[TGT_LOW] && !timer_off
       && flags_reg[FLAG_LUNF] && !irq_vec_done[FLAG_LUNF])
      |=> flags_reg[FLAG_LUNF])
      else $error("hard reset accepted while running");

   // A stopped half must not move, so a reload is only seen on a tick
   chk_low_reload: assert property (
      @(posedge ref_clk) disable iff (rst)
      (presc_tick && lo_zero && (dual || upper0 || hi_zero) && !clear_lo)
      |=> (low_count == $past(cfg.low_per)))
      else $error("low half did not reload its period");

   chk_low_count_down: assert property (
      @(posedge ref_clk) disable iff (rst)
      (presc_tick && !lo_zero && !clear_lo) |=> (low_count == $past(low_count) - 8'h01))
      else $error("low half did not count down");

   chk_off_wave_value: assert property (
      @(posedge ref_clk) disable iff (rst)
      (timer_off && !clear_lo && !clear_hi) |-> ##2 (wg_out == $past(out_val_reg, 2)))
      else $error("stopped waveform does not follow the value bits");

   chk_override_copy: assert property (
      @(posedge ref_clk) disable iff (rst)
      wr_oe |-> ##2 (out_override == $past(wr_data, 2)))
      else $error("output enable not passed to the override");

   chk_cmp_flag_sets: assert property (
      @(posedge ref_clk) disable iff (rst)
      lo_hit[0] |=> flags_reg[FLAG_CMP])
      else $error("compare match did not set its flag");

   chk_vector_clears: assert property (
      @(posedge ref_clk) disable iff (rst)
      (irq_vec_done[FLAG_LUNF] && !lo_unf) |=> !flags_reg[FLAG_LUNF])
      else $error("vector done did not clear the low underflow flag");

   chk_high_irq_level: assert property (
      @(posedge ref_clk) disable iff (rst)
      flags_reg[FLAG_HUNF] |=> (irq_req.high_unf == $past(unf_lvl_reg[3:2])))
      else $error("high underflow request level wrong");

   chk_level_zero_off: assert property (
      @(posedge ref_clk) disable iff (rst)
      (unf_lvl_reg[3:2] == 2'h0) |=> (irq_req.high_unf == 2'h0))
      else $error("disabled high underflow still requests");

   chk_cmp_irq_level: assert property (
      @(posedge ref_clk) disable iff (rst)
      flags_reg[FLAG_CMP+3] |=> (irq_req.low_cmp[3] == $past(cmp_lvl_reg[7:6])))
      else $error("compare D request level wrong");

   chk_restart_high: assert property (
      @(posedge ref_clk) disable iff (rst)
      restart_hi |=> (high_count == RST_BYTE) ##1 (wg_out[7:4] == 4'h0))
      else $error("restart did not clear the high half");

endmodule : sdbt_regs
`default_nettype wire

/* testbench/tb_sdbt_regs.sv */
// Self-checking bench for the split dual byte timer register set.
// Assumes sdbt_regs is the top; period and compare values come from cfg here.
`timescale 1ns/1ps
`default_nettype none
module tb_sdbt_regs;
   import sdbt_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wr_data = 8'h00;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [7:0]  rd_data;
   logic [7:0]  event_in = 8'h00;
   sdbt_cfg_t   cfg;
   logic [7:0]  irq_vec_done = 8'h00;
   logic [7:0]  wg_out;
   logic [7:0]  out_override;
   logic [7:0]  low_count;
   logic [7:0]  high_count;
   sdbt_irq_t   irq_req;
   int          mismatches = 0;
   int          tests_run = 0;
   int          cycles = 0;
   logic [7:0]  d_lo;
   logic [7:0]  d_hi;
   logic [7:0]  rv;
   int          div_tab [7] = '{1, 2, 4, 8, 64, 256, 1024};
   logic [7:0]  mode_hi [4] = '{8'h01, 8'h00, 8'h00, 8'h01};
   logic [3:0]  map_a [9] = '{ADDR_CLK, ADDR_OE, ADDR_OV, ADDR_MODE, ADDR_UIRQ,
                              ADDR_CIRQ, ADDR_CMD, ADDR_FLAGS, 4'h3};
   logic [7:0]  map_m [9] = '{8'h0f, 8'hff, 8'hff, 8'h03, 8'h0f,
                              8'hff, 8'h03, 8'h00, 8'h00};
   logic [7:0]  map_w [9] = '{8'h0f, 8'hff, 8'hff, 8'h03, 8'h0f,
                              8'hff, 8'h0f, 8'hf3, 8'hff};

   sdbt_regs i_sdbt_regs (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .addr         (addr),
      .wr_data      (wr_data),
      .wr_en        (wr_en),
      .rd_en        (rd_en),
      .rd_data      (rd_data),
      .event_in     (event_in),
      .cfg          (cfg),
      .irq_vec_done (irq_vec_done),
      .wg_out       (wg_out),
      .out_override (out_override),
      .low_count    (low_count),
      .high_count   (high_count),
      .irq_req      (irq_req)
   );

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   // Hang guard, far above the roughly 7000 cycles the tests need
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // Register port: one-cycle strobes, read data only in the following cycle
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge ref_clk);
      wr_en   <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask : reg_rd

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : wait_cyc

   // Count movement over a whole number of tick periods, so divider phase drops out
   task automatic measure(input int n);
      logic [7:0] l0;
      logic [7:0] h0;
      wait_cyc(1);
      l0 = low_count;
      h0 = high_count;
      wait_cyc(n);
      d_lo = l0 - low_count;
      d_hi = h0 - high_count;
   endtask : measure

   task automatic pulse(input int n);
      @(posedge ref_clk);
      event_in <= 8'h01 << n;
      @(posedge ref_clk);
      event_in <= 8'h00;
   endtask : pulse

   initial begin
      cfg = '0;
      cfg.low_per  = 8'hff;
      cfg.high_per = 8'hff;
      cfg.low_cmp  = {4{8'h80}};
      cfg.high_cmp = {4{8'h80}};
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values, then stored bits of each offset; unmapped one stays zero
      for (int i = 0; i < 9; i++) begin
         reg_rd(map_a[i], rv);
         check(rv, 8'h00);
         reg_wr(map_a[i], map_w[i]);
         reg_rd(map_a[i], rv);
         check(rv, map_m[i]);
         reg_wr(map_a[i], 8'h00);
      end
      // Stopped timer: value bits reach the waveform outputs
      reg_wr(ADDR_OV, 8'ha5);
      reg_wr(ADDR_OE, 8'h3c);
      wait_cyc(3);
      check(wg_out, 8'ha5);
      check(out_override, 8'h3c);
      reg_wr(ADDR_OV, 8'h5a);
      measure(20);
      check(wg_out, 8'h5a);
      check(d_lo, 8'h00);
      check(d_hi, 8'h00);
      // Every prescaler code, both halves in split mode
      reg_wr(ADDR_MODE, 8'h02);
      for (int k = 1; k < 8; k++) begin
         reg_wr(ADDR_CLK, 8'(k));
         wait_cyc(3);
         measure(4 * div_tab[k-1]);
         check(d_lo, 8'h04);
         check(d_hi, 8'h04);
      end
      // Every event channel; a pulse on the wrong channel must not count
      for (int n = 0; n < 8; n++) begin
         reg_wr(ADDR_CLK, 8'(8 + n));
         wait_cyc(3);
         rv = low_count;
         repeat (3) pulse(n);
         pulse((n + 1) % 8);
         wait_cyc(3);
         check(8'(rv - low_count), 8'h03);
      end
      // All width modes over 256 ticks: chained high steps once per low wrap
      reg_wr(ADDR_CLK, 8'h01);
      for (int m = 0; m < 4; m++) begin
         reg_wr(ADDR_MODE, 8'(m));
         wait_cyc(3);
         measure(256);
         check(d_lo, 8'h00);
         check(d_hi, mode_hi[m]);
         if (m == 1) begin
            check(high_count, 8'h00);
         end
      end
      // Event clock with no events: running but frozen, so commands show alone
      reg_wr(ADDR_MODE, 8'h02);
      reg_wr(ADDR_CLK, 8'h08);
      wait_cyc(3);
      d_lo = low_count;
      d_hi = high_count;
      reg_wr(ADDR_CMD, 8'h0f);
      reg_wr(ADDR_CMD, 8'h08);
      wait_cyc(2);
      check(low_count, d_lo);
      check(high_count, d_hi);
      reg_wr(ADDR_CMD, 8'h09);
      wait_cyc(2);
      check(low_count, 8'h00);
      check(high_count, d_hi);
      reg_wr(ADDR_CMD, 8'h0a);
      wait_cyc(2);
      check(high_count, 8'h00);
      check(wg_out, 8'h00);
      // Short periods with compare hits, then stop and inspect the flags
      reg_wr(ADDR_FLAGS, 8'hf3);
      cfg.low_per  <= 8'h03;
      cfg.high_per <= 8'h03;
      cfg.low_cmp  <= {4{8'h02}};
      reg_wr(ADDR_CLK, 8'h01);
      wait_cyc(20);
      reg_wr(ADDR_CLK, 8'h00);
      wait_cyc(4);
      reg_rd(ADDR_FLAGS, rv);
      check(rv, 8'hf3);
      check(irq_req, 12'h000);
      reg_wr(ADDR_UIRQ, 8'h0e);
      reg_wr(ADDR_CIRQ, 8'he4);
      wait_cyc(2);
      check(irq_req, 12'he4e);
      reg_wr(ADDR_FLAGS, 8'h01);
      reg_rd(ADDR_FLAGS, rv);
      check(rv, 8'hf2);
      wait_cyc(1);
      check(irq_req, 12'he4c);
      @(posedge ref_clk);
      irq_vec_done <= 8'h80;
      @(posedge ref_clk);
      irq_vec_done <= 8'h00;
      reg_rd(ADDR_FLAGS, rv);
      check(rv, 8'h72);
      wait_cyc(1);
      check(irq_req, 12'h24c);
      // Hard reset of the high half while stopped
      reg_wr(ADDR_CMD, 8'h0e);
      reg_rd(ADDR_FLAGS, rv);
      check(rv, 8'h70);
      check(high_count, 8'h00);
      wait_cyc(2);
      check(wg_out, 8'h5a);
      final_report();
   end
endmodule : tb_sdbt_regs
`default_nettype wire
